// File: hdl/pcrs_pkg.sv
// Constants and types shared by the program counter and return stack unit
package pcrs_pkg;
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam int STACK_DEPTH = 31;
  localparam int REG_ADDR_W = 12;
  localparam int CFG_WORDS = 4;
  localparam int CFG_TAIL_BYTES = 8;
  localparam int CFG_FAULT_RST_BIT = 5;
  localparam int SP_REG_FULL_BIT = 7;
  localparam int SP_REG_UNF_BIT = 6;

  localparam logic [20:0] RESET_VECTOR = 21'h000000;
  localparam logic [20:0] HI_INT_VECTOR = 21'h000008;
  localparam logic [20:0] LO_INT_VECTOR = 21'h000018;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [4:0] SP_EMPTY = 5'h00;
  localparam logic [4:0] SP_FULL = 5'h1f;
  localparam logic [15:0] CFG_WORD_RESET = 16'hffff;

  localparam logic [11:0] PC_LOW_BYTE_OFS = 12'hff9;
  localparam logic [11:0] PC_MIDDLE_LATCH_OFS = 12'hffa;
  localparam logic [11:0] PC_UPPER_LATCH_OFS = 12'hffb;
  localparam logic [11:0] RETURN_STACK_POINTER_OFS = 12'hffc;
  localparam logic [11:0] TOP_ENTRY_LOW_OFS = 12'hffd;
  localparam logic [11:0] TOP_ENTRY_HIGH_OFS = 12'hffe;
  localparam logic [11:0] TOP_ENTRY_UPPER_OFS = 12'hfff;

  typedef enum logic [3:0] {
    PCRS_CMD_NOP,
    PCRS_CMD_ADVANCE,
    PCRS_CMD_JUMP,
    PCRS_CMD_CALL,
    PCRS_CMD_RETURN,
    PCRS_CMD_UNLINK,
    PCRS_CMD_INT_HI,
    PCRS_CMD_INT_LO,
    PCRS_CMD_PUSH_SW,
    PCRS_CMD_POP_SW
  } pcrs_cmd_e;

  typedef enum logic [0:0] {
    PCRS_CFG_LOAD,
    PCRS_RUN
  } pcrs_state_e;
endpackage : pcrs_pkg

// File: hdl/pcrs_stack_if.sv
// Port bundle between the control logic and the return stack storage
`timescale 1ns/1ps
interface pcrs_stack_if;
  logic we;
  logic [4:0] waddr;
  logic [20:0] wdata;
  logic [4:0] raddr;
  logic [20:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : pcrs_stack_if

// File: hdl/pcrs_stack_ram.sv
// Return stack storage, entries 1 to 31
`timescale 1ns/1ps
module pcrs_stack_ram (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // Storage port
  pcrs_stack_if.store st
);
  import pcrs_pkg::*;

  logic [20:0] entry [1:STACK_DEPTH];

  generate
    for (genvar i = 1; i <= STACK_DEPTH; i++) begin : g_entry
      always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          entry[i] <= 21'h000000;
        end else if (clk_en_in && st.we && st.waddr == 5'(i)) begin
          entry[i] <= st.wdata;
        end
      end
    end
  endgenerate

  // Pointer zero reads as zero, there is no entry behind it
  assign st.rdata = (st.raddr == SP_EMPTY) ? 21'h000000 : entry[st.raddr];
endmodule : pcrs_stack_ram

// File: hdl/pcrs_unit.sv
// Program counter, latches, configuration copy and return stack control
`timescale 1ns/1ps
module pcrs_unit #(
  parameter int MEM_BYTES = 65536
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // Sequencer
  input wire pcrs_pkg::pcrs_cmd_e cmd_in,
  input wire logic [20:0] target_in,
  input wire logic ext_set_en_in,
  input wire logic dev_reset_in,
  // Program memory
  output logic [20:0] mem_addr_out,
  input wire logic [15:0] mem_rdata_in,
  output logic [15:0] instr_out,
  // Register port
  input wire logic [11:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Status
  output logic [20:0] pc_out,
  output logic [63:0] cfg_words_out,
  output logic cfg_done_out,
  output logic stack_reset_out
);
  import pcrs_pkg::*;

  localparam logic [20:0] CFG_BASE = 21'(MEM_BYTES - CFG_TAIL_BYTES);
  localparam logic [21:0] MEM_TOP = 22'(MEM_BYTES);

  pcrs_stack_if stk ();

  pcrs_stack_ram u_ram (
    .ref_clk_in (ref_clk_in),
    .rstn_in (rstn_in),
    .clk_en_in (clk_en_in),
    .st (stk.store)
  );

  logic [20:0] pc;
  logic [4:0] sp;
  logic [7:0] pc_middle_latch;
  logic [4:0] pc_upper_latch;
  logic stack_full_flag;
  logic stack_underflow_flag;
  pcrs_state_e state;
  logic [1:0] cfg_idx;
  logic [15:0] cfg_word [0:CFG_WORDS-1];

  logic soft_rst;
  logic run;
  logic stack_fault_reset_option;
  logic do_push;
  logic do_pop;
  logic pop_to_pc;
  logic [20:0] branch_pc;
  logic [20:0] next_pc;
  logic [4:0] next_sp;
  logic set_full;
  logic set_unf;
  logic fault;
  logic push_we;
  logic tos_we;
  logic [20:0] tos_wdata;
  logic wr_pc_low;
  logic wr_sp;
  logic wr_tos;
  pcrs_state_e next_state;
  logic [1:0] next_cfg_idx;
  logic [20:0] next_mem_addr;

  // Stack fault reset and device reset both restart the unit from the vector
  assign soft_rst = dev_reset_in | stack_reset_out;
  assign run = (state == PCRS_RUN) && !soft_rst;
  assign stack_fault_reset_option = cfg_word[0][CFG_FAULT_RST_BIT];
  assign wr_pc_low = reg_wr_in && reg_addr_in == PC_LOW_BYTE_OFS;
  assign wr_sp = reg_wr_in && reg_addr_in == RETURN_STACK_POINTER_OFS;
  assign wr_tos = reg_wr_in && (reg_addr_in == TOP_ENTRY_LOW_OFS ||
    reg_addr_in == TOP_ENTRY_HIGH_OFS || reg_addr_in == TOP_ENTRY_UPPER_OFS);

  // Sequencer command decode
  always_comb begin
    do_push = 1'b0;
    do_pop = 1'b0;
    pop_to_pc = 1'b0;
    branch_pc = pc + PC_STEP;
    if (run) begin
      case (cmd_in)
        PCRS_CMD_ADVANCE: branch_pc = pc + PC_STEP;
        PCRS_CMD_JUMP: branch_pc = {target_in[20:1], 1'b0};
        PCRS_CMD_CALL: begin
          do_push = 1'b1;
          branch_pc = {target_in[20:1], 1'b0};
        end
        PCRS_CMD_INT_HI: begin
          do_push = 1'b1;
          branch_pc = HI_INT_VECTOR;
        end
        PCRS_CMD_INT_LO: begin
          do_push = 1'b1;
          branch_pc = LO_INT_VECTOR;
        end
        PCRS_CMD_RETURN: begin
          do_pop = 1'b1;
          pop_to_pc = 1'b1;
        end
        PCRS_CMD_UNLINK: begin
          do_pop = ext_set_en_in;
          pop_to_pc = ext_set_en_in;
        end
        PCRS_CMD_PUSH_SW: do_push = 1'b1;
        PCRS_CMD_POP_SW: do_pop = 1'b1;
        default: branch_pc = pc;
      endcase
    end
  end

  // Stack pointer, counter and fault resolution
  always_comb begin
    next_pc = pc;
    next_sp = sp;
    set_full = 1'b0;
    set_unf = 1'b0;
    fault = 1'b0;
    push_we = 1'b0;
    if (soft_rst) begin
      next_pc = RESET_VECTOR;
      next_sp = SP_EMPTY;
    end else if (run && cmd_in != PCRS_CMD_NOP) begin
      next_pc = branch_pc;
      if (do_push) begin
        if (sp == SP_FULL) begin
          set_full = 1'b1;
          fault = stack_fault_reset_option;
        end else begin
          next_sp = sp + 5'h01;
          push_we = 1'b1;
          set_full = (sp + 5'h01) == SP_FULL;
          fault = set_full && stack_fault_reset_option;
        end
      end else if (do_pop) begin
        if (sp == SP_EMPTY) begin
          set_unf = 1'b1;
          fault = stack_fault_reset_option;
          if (pop_to_pc) begin
            next_pc = RESET_VECTOR;
          end
        end else begin
          next_sp = sp - 5'h01;
          if (pop_to_pc) begin
            next_pc = {stk.rdata[20:1], 1'b0};
          end
        end
      end
    end else if (state == PCRS_RUN && cmd_in == PCRS_CMD_NOP) begin
      if (wr_pc_low) begin
        next_pc = {pc_upper_latch, pc_middle_latch, reg_wdata_in[7:1], 1'b0};
      end
      if (wr_sp) begin
        next_sp = reg_wdata_in[4:0];
      end
    end
  end

  // Top-of-stack write merges one byte into the entry under the pointer
  always_comb begin
    tos_wdata = stk.rdata;
    case (reg_addr_in)
      TOP_ENTRY_LOW_OFS: tos_wdata[7:0] = reg_wdata_in;
      TOP_ENTRY_HIGH_OFS: tos_wdata[15:8] = reg_wdata_in;
      TOP_ENTRY_UPPER_OFS: tos_wdata[20:16] = reg_wdata_in[4:0];
      default: tos_wdata = stk.rdata;
    endcase
  end

  assign tos_we = wr_tos && run && cmd_in == PCRS_CMD_NOP && sp != SP_EMPTY;
  assign stk.we = push_we | tos_we;
  assign stk.waddr = push_we ? (sp + 5'h01) : sp;
  assign stk.wdata = push_we ? pc : tos_wdata;
  assign stk.raddr = sp;

  // Configuration copy sequence
  always_comb begin
    next_state = state;
    next_cfg_idx = cfg_idx;
    if (soft_rst) begin
      next_state = PCRS_CFG_LOAD;
      next_cfg_idx = 2'h0;
    end else if (state == PCRS_CFG_LOAD) begin
      next_cfg_idx = cfg_idx + 2'h1;
      if (cfg_idx == 2'h3) begin
        next_state = PCRS_RUN;
      end
    end
    if (next_state == PCRS_CFG_LOAD) begin
      next_mem_addr = CFG_BASE + {18'h00000, next_cfg_idx, 1'b0};
    end else begin
      next_mem_addr = next_pc;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= PCRS_CFG_LOAD;
      cfg_idx <= 2'h0;
      mem_addr_out <= CFG_BASE;
    end else if (clk_en_in) begin
      state <= next_state;
      cfg_idx <= next_cfg_idx;
      mem_addr_out <= next_mem_addr;
    end
  end

  // Word k takes the even byte as low half, so bytes ascend through the block
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int k = 0; k < CFG_WORDS; k++) begin
        cfg_word[k] <= CFG_WORD_RESET;
      end
    end else if (clk_en_in && state == PCRS_CFG_LOAD && !soft_rst) begin
      cfg_word[cfg_idx] <= mem_rdata_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_done_out <= 1'b0;
      cfg_words_out <= {CFG_WORDS{CFG_WORD_RESET}};
    end else if (clk_en_in) begin
      cfg_done_out <= (next_state == PCRS_RUN);
      cfg_words_out <= {cfg_word[3], cfg_word[2], cfg_word[1], cfg_word[0]};
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc <= RESET_VECTOR;
      pc_out <= RESET_VECTOR;
      sp <= SP_EMPTY;
    end else if (clk_en_in) begin
      pc <= next_pc;
      pc_out <= next_pc;
      sp <= next_sp;
    end
  end

  // Zero above implemented memory decodes as a no-operation
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      instr_out <= 16'h0000;
    end else if (clk_en_in) begin
      instr_out <= ({1'b0, mem_addr_out} >= MEM_TOP) ? 16'h0000 : mem_rdata_in;
    end
  end

  // The fault pulse lasts one cycle and then restarts the unit
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stack_reset_out <= 1'b0;
    end else if (clk_en_in) begin
      stack_reset_out <= fault;
    end
  end

  // Flags survive device resets; only power-on clears them besides software
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stack_full_flag <= 1'b0;
      stack_underflow_flag <= 1'b0;
    end else if (clk_en_in) begin
      stack_full_flag <= set_full | (stack_full_flag &
        !(wr_sp && !reg_wdata_in[SP_REG_FULL_BIT]));
      stack_underflow_flag <= set_unf | (stack_underflow_flag &
        !(wr_sp && !reg_wdata_in[SP_REG_UNF_BIT]));
    end
  end

  // Latches change only by register access, never by branches or returns
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_middle_latch <= 8'h00;
      pc_upper_latch <= 5'h00;
    end else if (clk_en_in) begin
      if (reg_rd_in && reg_addr_in == PC_LOW_BYTE_OFS) begin
        pc_middle_latch <= pc[15:8];
        pc_upper_latch <= pc[20:16];
      end else if (reg_wr_in && reg_addr_in == PC_MIDDLE_LATCH_OFS) begin
        pc_middle_latch <= reg_wdata_in;
      end else if (reg_wr_in && reg_addr_in == PC_UPPER_LATCH_OFS) begin
        pc_upper_latch <= reg_wdata_in[4:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      reg_rdata_out <= 8'h00;
      if (reg_rd_in) begin
        case (reg_addr_in)
          PC_LOW_BYTE_OFS: reg_rdata_out <= pc[7:0];
          PC_MIDDLE_LATCH_OFS: reg_rdata_out <= pc_middle_latch;
          PC_UPPER_LATCH_OFS: reg_rdata_out <= {3'h0, pc_upper_latch};
          RETURN_STACK_POINTER_OFS:
            reg_rdata_out <= {stack_full_flag, stack_underflow_flag, 1'b0, sp};
          TOP_ENTRY_LOW_OFS: reg_rdata_out <= stk.rdata[7:0];
          TOP_ENTRY_HIGH_OFS: reg_rdata_out <= stk.rdata[15:8];
          TOP_ENTRY_UPPER_OFS: reg_rdata_out <= {3'h0, stk.rdata[20:16]};
          default: reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  property p_reset_vector;
    clk_en_in && dev_reset_in |=> pc == RESET_VECTOR && sp == SP_EMPTY;
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("reset vector not loaded");

  property p_hi_vector;
    clk_en_in && run && cmd_in == PCRS_CMD_INT_HI |=> pc == HI_INT_VECTOR;
  endproperty
  a_hi_vector: assert property (p_hi_vector) else $error("high interrupt vector wrong");

  property p_advance;
    clk_en_in && run && cmd_in == PCRS_CMD_ADVANCE |=> pc == $past(pc) + PC_STEP;
  endproperty
  a_advance: assert property (p_advance) else $error("counter did not step by two");

  property p_aligned;
    pc[0] == 1'b0 && mem_addr_out[0] == 1'b0;
  endproperty
  a_aligned: assert property (p_aligned) else $error("counter misaligned");

  property p_call_push;
    clk_en_in && run && cmd_in == PCRS_CMD_CALL && sp < 5'h1e
      |=> sp == $past(sp) + 5'h01 && stk.rdata == $past(pc) && !stack_reset_out;
  endproperty
  a_call_push: assert property (p_call_push) else $error("push did not store counter");

  property p_underflow;
    clk_en_in && run && cmd_in == PCRS_CMD_RETURN && sp == SP_EMPTY
      |=> pc == RESET_VECTOR && sp == SP_EMPTY && stack_underflow_flag;
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow not handled");

  property p_full_stop;
    clk_en_in && run && cmd_in == PCRS_CMD_CALL && sp == 5'h1e && !stack_fault_reset_option
      |=> sp == SP_FULL && stack_full_flag && !stack_reset_out;
  endproperty
  a_full_stop: assert property (p_full_stop) else $error("full without reset wrong");

  property p_full_reset;
    clk_en_in && run && cmd_in == PCRS_CMD_CALL && sp == 5'h1e && stack_fault_reset_option
      |=> stack_reset_out && stack_full_flag && sp == SP_FULL;
  endproperty
  a_full_reset: assert property (p_full_reset) else $error("full fault reset missing");

  property p_fault_restart;
    stack_reset_out && clk_en_in |=> sp == SP_EMPTY && pc == RESET_VECTOR
      && state == PCRS_CFG_LOAD;
  endproperty
  a_fault_restart: assert property (p_fault_restart) else $error("fault did not restart");

  property p_low_read;
    clk_en_in && reg_rd_in && reg_addr_in == PC_LOW_BYTE_OFS
      |=> {pc_upper_latch, pc_middle_latch, 8'h00} == ($past(pc) & 21'h1fff00);
  endproperty
  a_low_read: assert property (p_low_read) else $error("latches not loaded on read");

  property p_low_write;
    clk_en_in && wr_pc_low && run && cmd_in == PCRS_CMD_NOP
      |=> pc == {$past(pc_upper_latch), $past(pc_middle_latch), $past(reg_wdata_in) & 8'hfe};
  endproperty
  a_low_write: assert property (p_low_write) else $error("low byte write wrong");

  c_full: cover property (clk_en_in && set_full);
  c_underflow: cover property (clk_en_in && set_unf);
  c_cfg_done: cover property (!cfg_done_out ##1 cfg_done_out);
  c_low_write: cover property (clk_en_in && wr_pc_low && run && cmd_in == PCRS_CMD_NOP);
endmodule : pcrs_unit

// File: verif/pcrs_mem_model.sv
// Program memory model facing the fetch port of the unit
`timescale 1ns/1ps
module pcrs_mem_model #(
  parameter int MEM_BYTES = 16384
) (
  // Fetch port
  input wire logic [20:0] mem_addr_in,
  input wire logic fault_opt_in,
  output logic [15:0] mem_rdata_out
);
  logic [20:0] cfg_base;
  assign cfg_base = 21'(MEM_BYTES - 8);
  always_comb begin
    if (mem_addr_in >= cfg_base && mem_addr_in < 21'(MEM_BYTES)) begin
      // Word k sits at base+2k, low byte even
      mem_rdata_out = 16'ha5c0 | {12'h0, mem_addr_in[2:1], 2'h0} | {10'h0, fault_opt_in, 5'h0};
    end else begin
      // Zero only where address bits 16 to 1 are all ones, so the unit must blank open space itself
      mem_rdata_out = ~mem_addr_in[16:1];
    end
  end
endmodule : pcrs_mem_model

// File: verif/tb_program_counter_return_stack.sv
// Self-checking bench for the program counter and return stack unit
`timescale 1ns/1ps
module tb_program_counter_return_stack;
  import pcrs_pkg::*;
  localparam int MB = 16384;
  logic ref_clk_in, rstn_in, clk_en, ext_en, dev_reset, reg_wr, reg_rd, fault_opt;
  logic cfg_done, stack_reset;
  pcrs_cmd_e cmd;
  logic [20:0] target, mem_addr, pc;
  logic [15:0] mem_rdata, instr;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [63:0] cfg_words;
  int n_errors, samples_checked;

  pcrs_unit #(.MEM_BYTES(MB)) i_pcrs_unit (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en),
    .cmd_in(cmd), .target_in(target), .ext_set_en_in(ext_en), .dev_reset_in(dev_reset),
    .mem_addr_out(mem_addr), .mem_rdata_in(mem_rdata), .instr_out(instr),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .pc_out(pc),
    .cfg_words_out(cfg_words), .cfg_done_out(cfg_done), .stack_reset_out(stack_reset)
  );
  pcrs_mem_model #(.MEM_BYTES(MB)) i_pcrs_mem_model (
    .mem_addr_in(mem_addr), .fault_opt_in(fault_opt), .mem_rdata_out(mem_rdata)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic cmd_go(input pcrs_cmd_e c, input logic [20:0] t);
    @(posedge ref_clk_in);
    cmd <= c;
    target <= t;
    @(posedge ref_clk_in);
    cmd <= PCRS_CMD_NOP;
  endtask : cmd_go

  task automatic reg_wr_go(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr <= 1'b0;
  endtask : reg_wr_go

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd_go(input logic [11:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd <= 1'b0;
    @(negedge ref_clk_in);
    d = reg_rdata;
  endtask : reg_rd_go

  task automatic chk_pc(input logic [20:0] e);
    @(negedge ref_clk_in);
    chk("pc", e, pc);
  endtask : chk_pc

  task automatic chk_ptr(input logic [7:0] e);
    reg_rd_go(RETURN_STACK_POINTER_OFS, rv);
    chk("pointer", e, rv);
  endtask : chk_ptr

  task automatic tos_chk(input logic [20:0] e);
    logic [20:0] got;
    reg_rd_go(TOP_ENTRY_LOW_OFS, got[7:0]);
    reg_rd_go(TOP_ENTRY_HIGH_OFS, got[15:8]);
    reg_rd_go(TOP_ENTRY_UPPER_OFS, rv);
    got[20:16] = rv[4:0];
    chk("top entry", e, got);
  endtask : tos_chk

  // Skip the cycles where the old run state may still show
  task automatic wait_run;
    int n;
    n = 0;
    repeat (2) @(negedge ref_clk_in);
    while (cfg_done !== 1'b1 && n < 40) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk("cfg_done", 1'b1, cfg_done);
  endtask : wait_run

  task automatic cfg_chk;
    // Word bus lags the done flag by one cycle
    @(negedge ref_clk_in);
    for (int k = 0; k < 4; k++) begin
      chk("cfg word", 16'ha5c0 | 16'(k << 2) | {10'h0, fault_opt, 5'h0}, cfg_words[16*k +: 16]);
    end
  endtask : cfg_chk

  task automatic t_reset;
    wait_run();
    chk("pc", 21'h0, pc);
    cfg_chk();
    chk_ptr(8'h00);
    reg_rd_go(12'h100, rv);
    chk("unmapped", 8'h00, rv);
    $display("reset test done");
  endtask : t_reset

  task automatic t_seq;
    cmd_go(PCRS_CMD_ADVANCE, 21'h0);
    chk_pc(21'h000002);
    cmd_go(PCRS_CMD_UNLINK, 21'h0);
    chk_pc(21'h000004);
    reg_wr_go(PC_MIDDLE_LATCH_OFS, 8'h12);
    reg_wr_go(PC_UPPER_LATCH_OFS, 8'h03);
    cmd_go(PCRS_CMD_JUMP, 21'h1abcd);
    chk_pc(21'h1abcc);
    @(posedge ref_clk_in);
    clk_en <= 1'b0;
    cmd <= PCRS_CMD_ADVANCE;
    repeat (2) @(posedge ref_clk_in);
    clk_en <= 1'b1;
    cmd <= PCRS_CMD_NOP;
    chk_pc(21'h1abcc);
    reg_rd_go(PC_MIDDLE_LATCH_OFS, rv);
    chk("middle latch", 8'h12, rv);
    reg_rd_go(PC_UPPER_LATCH_OFS, rv);
    chk("upper latch", 5'h03, rv[4:0]);
    $display("sequence test done");
  endtask : t_seq

  task automatic t_latch;
    reg_wr_go(PC_MIDDLE_LATCH_OFS, 8'h34);
    reg_wr_go(PC_UPPER_LATCH_OFS, 8'h05);
    reg_wr_go(PC_LOW_BYTE_OFS, 8'h57);
    chk_pc(21'h053456);
    cmd_go(PCRS_CMD_JUMP, 21'h0abcde);
    reg_rd_go(PC_LOW_BYTE_OFS, rv);
    chk("low byte", 8'hde, rv);
    reg_rd_go(PC_MIDDLE_LATCH_OFS, rv);
    chk("middle latch", 8'hbc, rv);
    reg_rd_go(PC_UPPER_LATCH_OFS, rv);
    chk("upper latch", 5'h0a, rv[4:0]);
    $display("latch test done");
  endtask : t_latch

  task automatic t_fetch;
    logic [20:0] a;
    logic [15:0] d;
    for (int j = 0; j < 2; j++) begin
      cmd_go(PCRS_CMD_JUMP, (j == 0) ? 21'h100000 : 21'h000100);
      for (int i = 0; i < 4; i++) begin
        @(negedge ref_clk_in);
        a = mem_addr;
        chk("fetch address", (j == 0) ? 21'h100000 : 21'h000100, a);
        d = mem_rdata;
        @(negedge ref_clk_in);
        chk("fetched word", (a >= 21'(MB)) ? 16'h0 : d, instr);
      end
    end
    $display("fetch test done");
  endtask : t_fetch

  task automatic t_stack;
    cmd_go(PCRS_CMD_JUMP, 21'h000200);
    cmd_go(PCRS_CMD_INT_HI, 21'h0);
    chk_pc(HI_INT_VECTOR);
    chk_ptr(8'h01);
    tos_chk(21'h000200);
    cmd_go(PCRS_CMD_INT_LO, 21'h0);
    chk_pc(LO_INT_VECTOR);
    cmd_go(PCRS_CMD_CALL, 21'h001234);
    chk_pc(21'h001234);
    chk_ptr(8'h03);
    cmd_go(PCRS_CMD_RETURN, 21'h0);
    chk_pc(LO_INT_VECTOR);
    @(posedge ref_clk_in);
    ext_en <= 1'b1;
    cmd_go(PCRS_CMD_UNLINK, 21'h0);
    chk_pc(HI_INT_VECTOR);
    cmd_go(PCRS_CMD_RETURN, 21'h0);
    chk_pc(21'h000200);
    cmd_go(PCRS_CMD_PUSH_SW, 21'h0);
    chk_pc(21'h000202);
    reg_wr_go(TOP_ENTRY_LOW_OFS, 8'h44);
    reg_wr_go(TOP_ENTRY_HIGH_OFS, 8'h33);
    reg_wr_go(TOP_ENTRY_UPPER_OFS, 8'h01);
    tos_chk(21'h013344);
    cmd_go(PCRS_CMD_RETURN, 21'h0);
    chk_pc(21'h013344);
    cmd_go(PCRS_CMD_PUSH_SW, 21'h0);
    cmd_go(PCRS_CMD_PUSH_SW, 21'h0);
    cmd_go(PCRS_CMD_POP_SW, 21'h0);
    chk_ptr(8'h01);
    tos_chk(21'h013344);
    cmd_go(PCRS_CMD_RETURN, 21'h0);
    chk_ptr(8'h00);
    $display("stack test done");
  endtask : t_stack

  task automatic t_full;
    reg_wr_go(RETURN_STACK_POINTER_OFS, 8'h1d);
    chk_ptr(8'h1d);
    cmd_go(PCRS_CMD_CALL, 21'h000400);
    cmd_go(PCRS_CMD_CALL, 21'h000500);
    chk_ptr(8'h9f);
    cmd_go(PCRS_CMD_CALL, 21'h000600);
    @(negedge ref_clk_in);
    chk("fault reset", 1'b0, stack_reset);
    chk_ptr(8'h9f);
    tos_chk(21'h000400);
    reg_wr_go(RETURN_STACK_POINTER_OFS, 8'h40);
    chk_ptr(8'h00);
    cmd_go(PCRS_CMD_JUMP, 21'h000300);
    cmd_go(PCRS_CMD_RETURN, 21'h0);
    chk_pc(21'h0);
    chk("fault reset", 1'b0, stack_reset);
    chk_ptr(8'h40);
    reg_wr_go(RETURN_STACK_POINTER_OFS, 8'h80);
    chk_ptr(8'h00);
    $display("full and underflow test done");
  endtask : t_full

  task automatic t_fault;
    @(posedge ref_clk_in);
    fault_opt <= 1'b1;
    dev_reset <= 1'b1;
    @(posedge ref_clk_in);
    dev_reset <= 1'b0;
    wait_run();
    cfg_chk();
    chk("pc", 21'h0, pc);
    reg_wr_go(RETURN_STACK_POINTER_OFS, 8'h1e);
    cmd_go(PCRS_CMD_JUMP, 21'h000700);
    cmd_go(PCRS_CMD_CALL, 21'h000800);
    @(negedge ref_clk_in);
    chk("fault reset", 1'b1, stack_reset);
    wait_run();
    chk("pc", 21'h0, pc);
    chk_ptr(8'h80);
    cmd_go(PCRS_CMD_RETURN, 21'h0);
    @(negedge ref_clk_in);
    chk("fault reset", 1'b1, stack_reset);
    wait_run();
    chk_ptr(8'hc0);
    reg_wr_go(RETURN_STACK_POINTER_OFS, 8'hdf);
    tos_chk(21'h000700);
    $display("fault reset test done");
  endtask : t_fault

  initial begin
    n_errors = 0;
    samples_checked = 0;
    rstn_in = 1'b0;
    clk_en = 1'b1;
    ext_en = 1'b0;
    dev_reset = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fault_opt = 1'b0;
    cmd = PCRS_CMD_NOP;
    target = 21'h0;
    reg_addr = 12'h0;
    reg_wdata = 8'h0;
    repeat (4) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_seq();
    t_latch();
    t_fetch();
    t_stack();
    t_full();
    t_fault();
    give_verdict();
  end

  // Tests take well under 1000 cycles
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
endmodule : tb_program_counter_return_stack
